// >>> logic/mdls_lane.sv
/*
  per-bus lane former: store data packing and load data unpacking for one 64-bit bus.
  assumes the top has already refused illegal combinations; purely combinational.
*/
`timescale 1ns/1ps
`default_nettype none
module mdls_lane
(
  // link to the steering top
  mdls_lane_if.lane lif
);
  import mdls_pkg::*;

  localparam int HI = MDLS_REG_W - 1;

  // second register: complement for simd normal, else the neighbour
  always_comb
  begin
    lif.implicit = lif.simd && (lif.req_width == MDLS_NORMAL);
    lif.sel_b_elem = lif.implicit ? mdls_elem_type'(~lif.req_elem) : lif.req_elem;
    lif.sel_b_idx = lif.implicit ? lif.req_idx : (lif.req_idx ^ MDLS_IDX_W'(1));
  end

  // store packing, unused lanes forced to zero
  always_comb
  begin
    lif.wdata = '0;
    unique case (lif.req_width)
      MDLS_NORMAL:
      begin
        lif.wdata[MDLS_LANE_W-1:0] = lif.rf_a_data[HI:MDLS_PAD_W];
        if (lif.implicit)
          lif.wdata[MDLS_BUS_W-1:MDLS_LANE_W] = lif.rf_b_data[HI:MDLS_PAD_W];
      end
      MDLS_EXT:
        lif.wdata = {lif.rf_a_data, {MDLS_EXT_PAD_W{1'b0}}};
      MDLS_LONG:
        if (!lif.req_idx[0])
          lif.wdata = {lif.rf_a_data[HI:MDLS_PAD_W], lif.rf_b_data[HI:MDLS_PAD_W]};
        else
          lif.wdata = {lif.rf_b_data[HI:MDLS_PAD_W], lif.rf_a_data[HI:MDLS_PAD_W]};
      default:
        lif.wdata = '0;
    endcase
  end

  // load unpacking into the named and second register
  always_comb
  begin
    lif.wr_a_en = lif.pend_valid;
    lif.wr_a_data = '0;
    lif.wr_b_en = 1'b0;
    lif.wr_b_elem = lif.pend_elem;
    lif.wr_b_idx = lif.pend_idx ^ MDLS_IDX_W'(1);
    lif.wr_b_data = '0;
    unique case (lif.pend_width)
      MDLS_NORMAL:
      begin
        lif.wr_a_data = {lif.mem_rdata[MDLS_LANE_W-1:0], {MDLS_PAD_W{1'b0}}};
        lif.wr_b_en = lif.pend_valid && lif.pend_implicit;
        lif.wr_b_elem = mdls_elem_type'(~lif.pend_elem);
        lif.wr_b_idx = lif.pend_idx;
        lif.wr_b_data = {lif.mem_rdata[MDLS_BUS_W-1:MDLS_LANE_W], {MDLS_PAD_W{1'b0}}};
      end
      MDLS_EXT:
        lif.wr_a_data = lif.mem_rdata[MDLS_BUS_W-1:MDLS_EXT_PAD_W];
      MDLS_LONG:
      begin
        lif.wr_b_en = lif.pend_valid;
        if (!lif.pend_idx[0])
        begin
          lif.wr_a_data = {lif.mem_rdata[MDLS_BUS_W-1:MDLS_LANE_W], {MDLS_PAD_W{1'b0}}};
          lif.wr_b_data = {lif.mem_rdata[MDLS_LANE_W-1:0], {MDLS_PAD_W{1'b0}}};
        end
        else
        begin
          lif.wr_a_data = {lif.mem_rdata[MDLS_LANE_W-1:0], {MDLS_PAD_W{1'b0}}};
          lif.wr_b_data = {lif.mem_rdata[MDLS_BUS_W-1:MDLS_LANE_W], {MDLS_PAD_W{1'b0}}};
        end
      end
      default:
        lif.wr_a_en = 1'b0;
    endcase
  end
endmodule : mdls_lane
`default_nettype wire

// >>> logic/mdls_lane_if.sv
/*
  carrier between the steering top and one per-bus lane former.
  assumes the top drives the request side and the lane module answers combinationally.
*/
`timescale 1ns/1ps
`default_nettype none
interface mdls_lane_if;
  import mdls_pkg::*;
  // request taken this cycle
  logic req_valid;
  logic req_write;
  mdls_width_type req_width;
  mdls_elem_type req_elem;
  logic [MDLS_IDX_W-1:0] req_idx;
  logic simd;
  logic [MDLS_REG_W-1:0] rf_a_data;
  logic [MDLS_REG_W-1:0] rf_b_data;
  // load pending from last cycle
  logic pend_valid;
  mdls_width_type pend_width;
  mdls_elem_type pend_elem;
  logic [MDLS_IDX_W-1:0] pend_idx;
  logic pend_implicit;
  logic [MDLS_BUS_W-1:0] mem_rdata;
  // answers
  logic implicit;
  mdls_elem_type sel_b_elem;
  logic [MDLS_IDX_W-1:0] sel_b_idx;
  logic [MDLS_BUS_W-1:0] wdata;
  logic wr_a_en;
  logic [MDLS_REG_W-1:0] wr_a_data;
  logic wr_b_en;
  mdls_elem_type wr_b_elem;
  logic [MDLS_IDX_W-1:0] wr_b_idx;
  logic [MDLS_REG_W-1:0] wr_b_data;

  modport top (output req_valid, req_write, req_width, req_elem, req_idx, simd, rf_a_data, rf_b_data,
    pend_valid, pend_width, pend_elem, pend_idx, pend_implicit, mem_rdata,
    input implicit, sel_b_elem, sel_b_idx, wdata, wr_a_en, wr_a_data, wr_b_en, wr_b_elem, wr_b_idx, wr_b_data);
  modport lane (input req_valid, req_write, req_width, req_elem, req_idx, simd, rf_a_data, rf_b_data,
    pend_valid, pend_width, pend_elem, pend_idx, pend_implicit, mem_rdata,
    output implicit, sel_b_elem, sel_b_idx, wdata, wr_a_en, wr_a_data, wr_b_en, wr_b_elem, wr_b_idx, wr_b_data);
endinterface : mdls_lane_if
`default_nettype wire

// >>> logic/mdls_pkg.sv
/*
  constants and types for the memory data lane steering block.
  assumes one core clock; bus index 0 is the data memory bus, 1 the program memory bus.
*/
package mdls_pkg;
  // bus and register geometry
  localparam int MDLS_BUS_W = 64;
  localparam int MDLS_REG_W = 40;
  localparam int MDLS_LANE_W = 32;
  localparam int MDLS_PAD_W = 8;
  localparam int MDLS_EXT_PAD_W = 24;
  localparam int MDLS_IDX_W = 4;
  localparam int MDLS_ADDR_W = 24;
  localparam int MDLS_NBUS = 2;
  // bus numbering
  localparam int MDLS_DMB = 0;
  localparam int MDLS_PMB = 1;
  // reset value of all registered state
  localparam logic MDLS_RST_VAL = 1'b0;

  // access width of one bus
  typedef enum logic [1:0]
  {
    MDLS_SHORT = 2'b00,
    MDLS_NORMAL = 2'b01,
    MDLS_EXT = 2'b10,
    MDLS_LONG = 2'b11
  } mdls_width_type;

  // processing element that owns a register
  typedef enum logic
  {
    MDLS_PRIMARY = 1'b0,
    MDLS_SECONDARY = 1'b1
  } mdls_elem_type;
endpackage : mdls_pkg

// >>> logic/mdls_steer.sv
/*
  memory data lane steering between the two 64-bit core buses and the register files.
  assumes combinational register file reads in the request cycle and memory read data
  presented in the cycle the memory request is shown; short word accesses are refused.
*/
`timescale 1ns/1ps
`default_nettype none
module mdls_steer
#(
  parameter int ADDR_W = mdls_pkg::MDLS_ADDR_W
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // core mode
  input wire logic simd_mode,
  // access requests, index 0 data memory bus, index 1 program memory bus
  input wire logic [mdls_pkg::MDLS_NBUS-1:0] req_valid,
  input wire logic [mdls_pkg::MDLS_NBUS-1:0] req_write,
  input wire mdls_pkg::mdls_width_type [mdls_pkg::MDLS_NBUS-1:0] req_width,
  input wire mdls_pkg::mdls_elem_type [mdls_pkg::MDLS_NBUS-1:0] req_elem,
  input wire logic [mdls_pkg::MDLS_NBUS-1:0][mdls_pkg::MDLS_IDX_W-1:0] req_idx,
  input wire logic [mdls_pkg::MDLS_NBUS-1:0][ADDR_W-1:0] req_addr,
  input wire logic [mdls_pkg::MDLS_NBUS-1:0] req_indirect,
  // register file read selects and data
  output logic [mdls_pkg::MDLS_NBUS-1:0] rf_b_sel_elem,
  output logic [mdls_pkg::MDLS_NBUS-1:0][mdls_pkg::MDLS_IDX_W-1:0] rf_b_sel_idx,
  input wire logic [mdls_pkg::MDLS_NBUS-1:0][mdls_pkg::MDLS_REG_W-1:0] rf_a_data,
  input wire logic [mdls_pkg::MDLS_NBUS-1:0][mdls_pkg::MDLS_REG_W-1:0] rf_b_data,
  // memory array side
  output logic [mdls_pkg::MDLS_NBUS-1:0] mem_valid,
  output logic [mdls_pkg::MDLS_NBUS-1:0] mem_write,
  output logic [mdls_pkg::MDLS_NBUS-1:0] mem_hi_en,
  output logic [mdls_pkg::MDLS_NBUS-1:0][ADDR_W-1:0] mem_addr,
  output logic [mdls_pkg::MDLS_NBUS-1:0][ADDR_W-1:0] mem_next_addr,
  output logic [mdls_pkg::MDLS_NBUS-1:0][mdls_pkg::MDLS_BUS_W-1:0] mem_wdata,
  input wire logic [mdls_pkg::MDLS_NBUS-1:0][mdls_pkg::MDLS_BUS_W-1:0] mem_rdata,
  // register file writes
  output logic [mdls_pkg::MDLS_NBUS-1:0] wr_a_en,
  output logic [mdls_pkg::MDLS_NBUS-1:0] wr_a_elem,
  output logic [mdls_pkg::MDLS_NBUS-1:0][mdls_pkg::MDLS_IDX_W-1:0] wr_a_idx,
  output logic [mdls_pkg::MDLS_NBUS-1:0][mdls_pkg::MDLS_REG_W-1:0] wr_a_data,
  output logic [mdls_pkg::MDLS_NBUS-1:0] wr_b_en,
  output logic [mdls_pkg::MDLS_NBUS-1:0] wr_b_elem,
  output logic [mdls_pkg::MDLS_NBUS-1:0][mdls_pkg::MDLS_IDX_W-1:0] wr_b_idx,
  output logic [mdls_pkg::MDLS_NBUS-1:0][mdls_pkg::MDLS_REG_W-1:0] wr_b_data,
  // refusal report
  output logic req_refused
);
  import mdls_pkg::*;

  // all registered state of the block
  typedef struct packed
  {
    logic [MDLS_NBUS-1:0] mem_valid;
    logic [MDLS_NBUS-1:0] mem_write;
    logic [MDLS_NBUS-1:0] mem_hi_en;
    logic [MDLS_NBUS-1:0][ADDR_W-1:0] mem_addr;
    logic [MDLS_NBUS-1:0][ADDR_W-1:0] mem_next_addr;
    logic [MDLS_NBUS-1:0][MDLS_BUS_W-1:0] mem_wdata;
    logic [MDLS_NBUS-1:0] pend_load;
    logic [MDLS_NBUS-1:0][1:0] pend_width;
    logic [MDLS_NBUS-1:0] pend_elem;
    logic [MDLS_NBUS-1:0][MDLS_IDX_W-1:0] pend_idx;
    logic [MDLS_NBUS-1:0] pend_implicit;
    logic [MDLS_NBUS-1:0] wr_a_en;
    logic [MDLS_NBUS-1:0] wr_a_elem;
    logic [MDLS_NBUS-1:0][MDLS_IDX_W-1:0] wr_a_idx;
    logic [MDLS_NBUS-1:0][MDLS_REG_W-1:0] wr_a_data;
    logic [MDLS_NBUS-1:0] wr_b_en;
    logic [MDLS_NBUS-1:0] wr_b_elem;
    logic [MDLS_NBUS-1:0][MDLS_IDX_W-1:0] wr_b_idx;
    logic [MDLS_NBUS-1:0][MDLS_REG_W-1:0] wr_b_data;
    logic refused;
  } mdls_state_type;

  mdls_state_type state;
  mdls_state_type next_state;

  // lane former answers gathered into plain arrays
  logic [MDLS_NBUS-1:0] lane_implicit;
  logic [MDLS_NBUS-1:0][MDLS_BUS_W-1:0] lane_wdata;
  logic [MDLS_NBUS-1:0] lane_wr_a_en;
  logic [MDLS_NBUS-1:0][MDLS_REG_W-1:0] lane_wr_a_data;
  logic [MDLS_NBUS-1:0] lane_wr_b_en;
  logic [MDLS_NBUS-1:0] lane_wr_b_elem;
  logic [MDLS_NBUS-1:0][MDLS_IDX_W-1:0] lane_wr_b_idx;
  logic [MDLS_NBUS-1:0][MDLS_REG_W-1:0] lane_wr_b_data;

  // legality of the combination taken this cycle
  logic dual;
  logic any_req;
  logic any_short;
  logic restricted;
  logic direct_bad;
  logic mix_bad;
  logic side_bad;
  logic refuse;

  mdls_lane_if lane_if [MDLS_NBUS] ();

  // one lane former per bus
  generate
    for (genvar b = 0; b < MDLS_NBUS; b++)
    begin : g_bus
      assign lane_if[b].req_valid = req_valid[b];
      assign lane_if[b].req_write = req_write[b];
      assign lane_if[b].req_width = req_width[b];
      assign lane_if[b].req_elem = req_elem[b];
      assign lane_if[b].req_idx = req_idx[b];
      assign lane_if[b].simd = simd_mode;
      assign lane_if[b].rf_a_data = rf_a_data[b];
      assign lane_if[b].rf_b_data = rf_b_data[b];
      assign lane_if[b].pend_valid = state.pend_load[b];
      assign lane_if[b].pend_width = mdls_width_type'(state.pend_width[b]);
      assign lane_if[b].pend_elem = mdls_elem_type'(state.pend_elem[b]);
      assign lane_if[b].pend_idx = state.pend_idx[b];
      assign lane_if[b].pend_implicit = state.pend_implicit[b];
      assign lane_if[b].mem_rdata = mem_rdata[b];

      assign lane_implicit[b] = lane_if[b].implicit;
      assign lane_wdata[b] = lane_if[b].wdata;
      assign lane_wr_a_en[b] = lane_if[b].wr_a_en;
      assign lane_wr_a_data[b] = lane_if[b].wr_a_data;
      assign lane_wr_b_en[b] = lane_if[b].wr_b_en;
      assign lane_wr_b_elem[b] = lane_if[b].wr_b_elem;
      assign lane_wr_b_idx[b] = lane_if[b].wr_b_idx;
      assign lane_wr_b_data[b] = lane_if[b].wr_b_data;
      // second register select goes straight to the register file read port
      assign rf_b_sel_elem[b] = lane_if[b].sel_b_elem;
      assign rf_b_sel_idx[b] = lane_if[b].sel_b_idx;

      mdls_lane u_lane
      (
        .lif (lane_if[b])
      );
    end
  endgenerate

  // combination checks; a refused access is dropped whole on both buses
  always_comb
  begin
    dual = req_valid[MDLS_DMB] && req_valid[MDLS_PMB];
    any_req = |req_valid;
    any_short = (req_valid[MDLS_DMB] && (req_width[MDLS_DMB] == MDLS_SHORT))
             || (req_valid[MDLS_PMB] && (req_width[MDLS_PMB] == MDLS_SHORT));
    // dual-data with a direct address on either bus is not steerable
    direct_bad = dual && !(&req_indirect);
    // wide simd dual-data leaves no room for implicit lanes
    restricted = simd_mode && dual
              && ((req_width[MDLS_DMB] == MDLS_EXT) || (req_width[MDLS_DMB] == MDLS_LONG)
               || (req_width[MDLS_PMB] == MDLS_EXT) || (req_width[MDLS_PMB] == MDLS_LONG));
    mix_bad = restricted
           && ((req_width[MDLS_DMB] == MDLS_NORMAL) || (req_width[MDLS_PMB] == MDLS_NORMAL));
    side_bad = restricted
            && ((req_elem[MDLS_DMB] != MDLS_PRIMARY) || (req_elem[MDLS_PMB] != MDLS_SECONDARY));
    // sisd dual-data needs no pairing check at all
    refuse = any_req && (any_short || direct_bad || mix_bad || side_bad);
  end

  // next state: memory request and load bookkeeping, then register writes
  always_comb
  begin
    next_state = state;
    next_state.refused = refuse;
    for (int b = 0; b < MDLS_NBUS; b++)
    begin
      // memory request for the access taken this cycle
      next_state.mem_valid[b] = req_valid[b] && !refuse;
      next_state.mem_write[b] = req_valid[b] && !refuse && req_write[b];
      next_state.mem_hi_en[b] = req_valid[b] && !refuse && (lane_implicit[b] || (req_width[b] != MDLS_NORMAL));
      next_state.mem_addr[b] = req_addr[b];
      // implicit word lives at the next normal word address regardless of parity
      next_state.mem_next_addr[b] = lane_implicit[b] ? ADDR_W'(req_addr[b] + ADDR_W'(1)) : req_addr[b];
      next_state.mem_wdata[b] = (req_valid[b] && req_write[b] && !refuse) ? lane_wdata[b] : '0;
      // loads wait one cycle for the array data
      next_state.pend_load[b] = req_valid[b] && !refuse && !req_write[b];
      next_state.pend_width[b] = req_width[b];
      next_state.pend_elem[b] = req_elem[b];
      next_state.pend_idx[b] = req_idx[b];
      next_state.pend_implicit[b] = lane_implicit[b];
      // register writes for the load now in the array
      next_state.wr_a_en[b] = lane_wr_a_en[b];
      next_state.wr_a_elem[b] = state.pend_elem[b];
      next_state.wr_a_idx[b] = state.pend_idx[b];
      next_state.wr_a_data[b] = lane_wr_a_data[b];
      next_state.wr_b_en[b] = lane_wr_b_en[b];
      next_state.wr_b_elem[b] = lane_wr_b_elem[b];
      next_state.wr_b_idx[b] = lane_wr_b_idx[b];
      next_state.wr_b_data[b] = lane_wr_b_data[b];
    end
  end

  // state register; everything clears so no stray write follows reset
  always_ff @(posedge sys_clk or negedge rst_b)
  begin
    if (!rst_b)
      state <= {$bits(mdls_state_type){MDLS_RST_VAL}};
    else
      state <= next_state;
  end

  // outputs straight from state
  assign mem_valid = state.mem_valid;
  assign mem_write = state.mem_write;
  assign mem_hi_en = state.mem_hi_en;
  assign mem_addr = state.mem_addr;
  assign mem_next_addr = state.mem_next_addr;
  assign mem_wdata = state.mem_wdata;
  assign wr_a_en = state.wr_a_en;
  assign wr_a_elem = state.wr_a_elem;
  assign wr_a_idx = state.wr_a_idx;
  assign wr_a_data = state.wr_a_data;
  assign wr_b_en = state.wr_b_en;
  assign wr_b_elem = state.wr_b_elem;
  assign wr_b_idx = state.wr_b_idx;
  assign wr_b_data = state.wr_b_data;
  assign req_refused = state.refused;
endmodule : mdls_steer
`default_nettype wire

// >>> testbench/mdls_mem_model.sv
/*
  register file and memory array model facing the steering block.
  assumes the bench keeps salt constant while traffic is in flight.
*/
`timescale 1ns/1ps
`default_nettype none
module mdls_mem_model
#(
  parameter int ADDR_W = 24
)
(
  // pattern seed
  input wire logic [31:0] salt,
  // register file reads
  input wire mdls_pkg::mdls_elem_type [1:0] req_elem,
  input wire logic [1:0][3:0] req_idx,
  input wire logic [1:0] rf_b_sel_elem,
  input wire logic [1:0][3:0] rf_b_sel_idx,
  output logic [1:0][39:0] rf_a_data,
  output logic [1:0][39:0] rf_b_data,
  // memory array
  input wire logic [1:0] mem_valid,
  input wire logic [1:0] mem_write,
  input wire logic [1:0][ADDR_W-1:0] mem_addr,
  output logic [1:0][63:0] mem_rdata
);
  import mdls_pkg::*;
  // register contents carry element and number, so a wrong select shows
  always_comb
  begin
    for (int b = 0; b < 2; b++)
    begin
      rf_a_data[b] = {salt, 3'h0, req_elem[b], req_idx[b]};
      rf_b_data[b] = {salt, 3'h0, rf_b_sel_elem[b], rf_b_sel_idx[b]};
      // inverted outside a load so stale data never passes for a match
      mem_rdata[b] = {salt, 8'h00, 24'(mem_addr[b])} ^ {64{!(mem_valid[b] && !mem_write[b])}};
    end
  end
endmodule : mdls_mem_model
`default_nettype wire

// >>> testbench/mdls_steer_assertions.sv
/*
  concurrent checks on the lane steering top ports.
  assumes one core clock and the active-low asynchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module mdls_steer_assertions
#(
  parameter int ADDR_W = 24
)
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // requests
  input wire logic simd_mode,
  input wire logic [1:0] req_valid,
  input wire mdls_pkg::mdls_width_type [1:0] req_width,
  input wire mdls_pkg::mdls_elem_type [1:0] req_elem,
  input wire logic [1:0] req_indirect,
  // memory side
  input wire logic [1:0] mem_valid,
  input wire logic [1:0] mem_write,
  input wire logic [1:0] mem_hi_en,
  input wire logic [1:0][ADDR_W-1:0] mem_addr,
  input wire logic [1:0][ADDR_W-1:0] mem_next_addr,
  input wire logic [1:0][63:0] mem_wdata,
  // register writes
  input wire logic [1:0] wr_a_en,
  input wire logic [1:0] wr_a_elem,
  input wire logic [1:0][3:0] wr_a_idx,
  input wire logic [1:0][39:0] wr_a_data,
  input wire logic [1:0] wr_b_en,
  input wire logic [1:0] wr_b_elem,
  input wire logic [1:0][3:0] wr_b_idx,
  input wire logic req_refused
);
  import mdls_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // refusals and a quiet memory side, then lane padding, implicit addressing and load write timing
  a_short_refused: assert property (req_valid[0] && req_width[0] == MDLS_SHORT
    |=> req_refused && mem_valid == 2'h0)
    else $error("short access was not refused");
  a_direct_dual: assert property (&req_valid && !(&req_indirect) |=> req_refused && mem_valid == 2'h0)
    else $error("dual access with direct address was taken");
  a_ext_elem_bind: assert property (simd_mode && &req_valid && req_width == {MDLS_EXT, MDLS_EXT}
    && req_elem[0] != MDLS_PRIMARY |=> req_refused)
    else $error("simd extended pair with wrong data bus element taken");
  a_simd_mix: assert property (simd_mode && &req_valid && req_width == {MDLS_NORMAL, MDLS_LONG}
    |=> req_refused)
    else $error("simd long with normal mix taken");
  a_ext_pad: assert property (mem_valid[0] && $past(req_width[0]) == MDLS_EXT |-> mem_wdata[0][23:0] == 24'h0)
    else $error("extended access low bits not zero");
  a_ext_single: assert property (mem_valid[1] && !mem_write[1] && $past(req_width[1]) == MDLS_EXT
    |=> wr_a_en[1] && !wr_b_en[1])
    else $error("extended load wrote a second register");
  a_normal_pad: assert property (wr_a_en[1] && $past(req_width[1], 2) == MDLS_NORMAL
    |-> wr_a_data[1][7:0] == 8'h00)
    else $error("normal load low byte not zero");
  a_sisd_hi_zero: assert property (mem_valid[1] && !$past(simd_mode) && $past(req_width[1]) == MDLS_NORMAL
    |-> !mem_hi_en[1] && mem_wdata[1][63:32] == 32'h0)
    else $error("sisd normal upper lane in use");
  a_implicit_next: assert property (mem_valid[0] && $past(simd_mode) && $past(req_width[0]) == MDLS_NORMAL
    |-> mem_hi_en[0] && mem_next_addr[0] == ADDR_W'(mem_addr[0] + 1))
    else $error("implicit address not the next word");
  a_long_neighbour: assert property (wr_b_en[0] && $past(req_width[0], 2) == MDLS_LONG
    |-> wr_b_elem[0] == wr_a_elem[0] && wr_b_idx[0] == (wr_a_idx[0] ^ 4'h1))
    else $error("long load second write not the neighbour");
  a_load_wr_delay: assert property (mem_valid[0] && !mem_write[0] |=> wr_a_en[0])
    else $error("load write not one cycle after memory strobe");
  // main scenarios reached
  c_simd_ext_long: cover property (simd_mode && &req_valid && req_width == {MDLS_LONG, MDLS_EXT}
    ##1 mem_valid == 2'h3);
  c_two_writes: cover property (wr_a_en[1] && wr_b_en[1]);
  c_refused: cover property (req_refused);
endmodule : mdls_steer_assertions
bind mdls_steer mdls_steer_assertions #(.ADDR_W(ADDR_W)) u_steer_chk (.sys_clk, .rst_b, .simd_mode, .req_valid,
  .req_width, .req_elem, .req_indirect, .mem_valid, .mem_write, .mem_hi_en, .mem_addr, .mem_next_addr, .mem_wdata,
  .wr_a_en, .wr_a_elem, .wr_a_idx, .wr_a_data, .wr_b_en, .wr_b_elem, .wr_b_idx, .req_refused);
`default_nettype wire

// >>> testbench/testbench.sv
/*
  random self-checking bench for the lane steering top against a queue-free model.
  assumes 24-bit addresses and the memory model answering loads in the strobe cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mdls_pkg::*;
  typedef struct packed {
    logic rf;
    logic [1:0] mv, mw, hi, ae, be, el, bel;
    logic [1:0][3:0] ix, bi;
    logic [1:0][23:0] ad, nx;
    logic [1:0][63:0] wd;
    logic [1:0][39:0] da, db;
  } mdls_tb_exp_type;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic simd_mode = 1'b0;
  logic [1:0] req_valid = 2'h0;
  logic [1:0] req_write = 2'h0;
  logic [1:0] req_indirect = 2'h0;
  mdls_width_type [1:0] req_width;
  mdls_elem_type [1:0] req_elem;
  logic [1:0][3:0] req_idx = 8'h00;
  logic [1:0][23:0] req_addr = 48'h0;
  logic [1:0] rf_b_sel_elem, mem_valid, mem_write, mem_hi_en, wr_a_en, wr_a_elem, wr_b_en, wr_b_elem;
  logic [1:0][3:0] rf_b_sel_idx, wr_a_idx, wr_b_idx;
  logic [1:0][23:0] mem_addr, mem_next_addr;
  logic [1:0][39:0] rf_a_data, rf_b_data, wr_a_data, wr_b_data;
  logic [1:0][63:0] mem_wdata, mem_rdata;
  logic req_refused;
  logic [31:0] salt = 32'h0;
  logic [31:0] seed = 32'h0000bdee;
  logic [31:0] r, q;
  int bad_count = 0;
  int cmp_count = 0;
  mdls_tb_exp_type e1, e2;

  mdls_steer #(.ADDR_W(24)) dut (.sys_clk, .rst_b, .simd_mode, .req_valid, .req_write, .req_width, .req_elem,
    .req_idx, .req_addr, .req_indirect, .rf_b_sel_elem, .rf_b_sel_idx, .rf_a_data, .rf_b_data, .mem_valid,
    .mem_write, .mem_hi_en, .mem_addr, .mem_next_addr, .mem_wdata, .mem_rdata, .wr_a_en, .wr_a_elem, .wr_a_idx,
    .wr_a_data, .wr_b_en, .wr_b_elem, .wr_b_idx, .wr_b_data, .req_refused);
  mdls_mem_model #(.ADDR_W(24)) u_mem (.salt, .req_elem, .req_idx, .rf_b_sel_elem, .rf_b_sel_idx, .rf_a_data,
    .rf_b_data, .mem_valid, .mem_write, .mem_addr, .mem_rdata);

  // 250 MHz core clock
  always #2 sys_clk = ~sys_clk;

  function automatic logic [31:0] nxt();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : nxt

  function automatic logic [39:0] rv(input logic e, input logic [3:0] i);
    return {salt, 3'h0, e, i};
  endfunction : rv

  // expected outcome of the request now on the inputs
  function automatic mdls_tb_exp_type calc();
    mdls_tb_exp_type x;
    logic rf, big, nrm, imp;
    logic [39:0] ra, rb, ev, od;
    logic [63:0] rd;
    x = '0;
    rf = 1'b0;
    big = 1'b0;
    nrm = 1'b0;
    for (int b = 0; b < 2; b++)
    begin
      if (req_valid[b])
      begin
        rf |= req_width[b] == MDLS_SHORT;
        big |= req_width[b] inside {MDLS_EXT, MDLS_LONG};
        nrm |= !(req_width[b] inside {MDLS_EXT, MDLS_LONG});
      end
    end
    rf |= &req_valid && !(&req_indirect);
    rf |= simd_mode && &req_valid && big
      && (nrm || req_elem[0] != MDLS_PRIMARY || req_elem[1] != MDLS_SECONDARY);
    x.rf = rf;
    for (int b = 0; b < 2; b++)
    begin
      if (req_valid[b] && !rf)
      begin
        imp = simd_mode && req_width[b] == MDLS_NORMAL;
        ra = rv(req_elem[b], req_idx[b]);
        rb = imp ? rv(~req_elem[b], req_idx[b]) : rv(req_elem[b], req_idx[b] ^ 4'h1);
        ev = req_idx[b][0] ? rb : ra;
        od = req_idx[b][0] ? ra : rb;
        rd = {salt, 8'h00, req_addr[b]};
        x.mv[b] = 1'b1;
        x.mw[b] = req_write[b];
        x.hi[b] = imp || req_width[b] != MDLS_NORMAL;
        x.ad[b] = req_addr[b];
        x.nx[b] = req_addr[b] + {23'h0, imp};
        x.ae[b] = !req_write[b];
        x.be[b] = !req_write[b] && (imp || req_width[b] == MDLS_LONG);
        x.el[b] = req_elem[b];
        x.ix[b] = req_idx[b];
        x.bel[b] = imp ? ~req_elem[b] : req_elem[b];
        x.bi[b] = imp ? req_idx[b] : req_idx[b] ^ 4'h1;
        case (req_width[b])
          MDLS_NORMAL:
          begin
            x.wd[b] = {imp ? rb[39:8] : 32'h0, ra[39:8]};
            x.da[b] = {rd[31:0], 8'h00};
            x.db[b] = {rd[63:32], 8'h00};
          end
          MDLS_EXT:
          begin
            x.wd[b] = {ra, 24'h0};
            x.da[b] = rd[63:24];
          end
          default:
          begin
            x.wd[b] = {ev[39:8], od[39:8]};
            x.da[b] = req_idx[b][0] ? {rd[31:0], 8'h00} : {rd[63:32], 8'h00};
            x.db[b] = req_idx[b][0] ? {rd[63:32], 8'h00} : {rd[31:0], 8'h00};
          end
        endcase
        if (!req_write[b])
          x.wd[b] = 64'h0;
      end
    end
    return x;
  endfunction : calc

  task automatic chk(input logic ok, input string msg);
    cmp_count++;
    if (ok !== 1'b1)
    begin
      bad_count++;
      $display("mismatch at %0t: %s", $time, msg);
    end
  endtask : chk

  // short and extended widths appear only in the later two phases; direct addresses appear in every phase
  task automatic drive(input logic [1:0] ph);
    r = nxt();
    q = nxt();
    simd_mode <= ph[0];
    req_valid <= r[1:0];
    req_write <= r[3:2];
    req_indirect <= {|r[7:5], |r[10:8]};
    req_width[0] <= mdls_width_type'(r[13:12] | {1'b0, !(ph[1] && r[11])});
    req_width[1] <= mdls_width_type'(r[15:14] | {1'b0, !(ph[1] && r[16])});
    req_elem[0] <= mdls_elem_type'(r[17] ? 1'b0 : r[18]);
    req_elem[1] <= mdls_elem_type'(r[17] | r[19]);
    req_idx[0] <= r[23:20];
    req_idx[1] <= r[27:24];
    req_addr[0] <= q[28] ? 24'hffffff : q[23:0];
    req_addr[1] <= {q[7:0], q[31:16]};
  endtask : drive

  task automatic check_step();
    for (int b = 0; b < 2; b++)
    begin
      chk(mem_valid[b] === e1.mv[b] && mem_write[b] === e1.mw[b], "memory strobe");
      if (e1.mv[b])
        chk({mem_hi_en[b], mem_addr[b], mem_next_addr[b], mem_wdata[b]}
          === {e1.hi[b], e1.ad[b], e1.nx[b], e1.wd[b]}, "memory lanes");
      chk(wr_a_en[b] === e2.ae[b] && wr_b_en[b] === e2.be[b], "write enables");
      if (e2.ae[b])
        chk({wr_a_elem[b], wr_a_idx[b], wr_a_data[b]} === {e2.el[b], e2.ix[b], e2.da[b]}, "named write");
      if (e2.be[b])
        chk({wr_b_elem[b], wr_b_idx[b], wr_b_data[b]} === {e2.bel[b], e2.bi[b], e2.db[b]},
          "second write");
      if (req_valid[b])
        chk({rf_b_sel_elem[b], rf_b_sel_idx[b]} === ((simd_mode && req_width[b] == MDLS_NORMAL)
          ? {~req_elem[b], req_idx[b]} : {req_elem[b], req_idx[b] ^ 4'h1}), "register select");
    end
    chk(req_refused === e1.rf, "refusal");
    e2 = e1;
    e1 = calc();
  endtask : check_step

  task automatic end_of_test();
    $display("compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  // phases alternate sisd and simd; the later two add short-width refusals
  initial
  begin
    req_width[0] = MDLS_NORMAL;
    req_width[1] = MDLS_NORMAL;
    req_elem[0] = MDLS_PRIMARY;
    req_elem[1] = MDLS_PRIMARY;
    e1 = '0;
    e2 = '0;
    salt = nxt();
    repeat (12) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int ph = 0; ph < 4; ph++)
    begin
      repeat (1500)
      begin
        @(posedge sys_clk);
        drive(ph[1:0]);
        @(negedge sys_clk);
        check_step();
      end
      $display("phase %0d done, %0d compares so far", ph, cmp_count);
    end
    end_of_test();
  end
endmodule : testbench
`default_nettype wire
